// file: verilog/rsw_reset_source_watchdog.sv
// Purpose: reset source selection, reset cause capture and watchdog timer
// Assumes: register writes arrive as one-cycle strobes on clk_sys_i
// Notes:   the missing clock one-shot runs on a free reference clock
//
// What this block does
// - enabled clock monitor resets when system clock stops beyond 100 us
// - clock monitor cause bit reads 1 after its reset; pin untouched
// - writing bit 2 of cause register enables or disables clock monitor
// - comparator enable bit makes low comparator output a reset source
// - comparator cause bit reads 1 after its reset; pin untouched
// - convert-start enable makes that input an active-low level reset
// - convert-start cause bit reads 1 after its reset; pin untouched
// - watchdog is 21-bit counter on system clock; overflow resets
// - every reset leaves watchdog enabled with interval bits all ones
// - writing 0xA5 enables the watchdog and restarts its count
// - 0xDE then 0xAD within 4 clocks disables watchdog; else ignored
// - writing 0xFF locks out disabling until next reset, no reload
// - timeout equals four to the power three plus interval, in clocks
// - interval written only when bit 7 is zero; read returns interval
// - bit 4 of watchdog control reads 1 while watchdog is running
// - software reset bit forces reset without pin; reads cause after
// - read-only watchdog cause bit reads 1 after a watchdog timeout
// - with monitor pin high bit 1 selects supply monitor; power-on cause
// - pin-reset bit forces power-on reset with pin driven low
// - low reset pin holds reset; exit at least 12 clocks after release
`timescale 1ns/1ps
`default_nettype none
module rsw_reset_source_watchdog (
  input  wire logic                  clk_sys_i,
  input  wire logic                  clk_ref_i,
  input  wire logic                  resetn_i,
  input  wire rsw_pkg::rsw_sfr_req_s sfr_req_i,
  output var  logic [7:0]            sfr_rdata_o,
  input  wire logic                  rst_pin_i,
  output var  logic                  rst_pin_o,
  output var  logic                  rst_pin_oe_o,
  input  wire logic                  supply_monitor_enable_pin_i,
  input  wire logic                  supply_low_i,
  input  wire logic                  comparator_out_i,
  input  wire logic                  second_convert_start_input_i,
  output var  logic                  convert_trigger_o,
  output var  logic                  system_reset_o,
  output var  logic                  mcd_reset_o
);

  logic [rsw_pkg::SY_W-1:0]      async_in;
  logic [rsw_pkg::SY_W-1:0]      sync1_q;
  logic [rsw_pkg::SY_W-1:0]      sync2_q;
  logic [2:0]                    beat_q;
  logic                          mcd_expired;
  rsw_pkg::rsw_state_e           state_q;
  rsw_pkg::rsw_state_e           state_d;
  logic [6:0]                    cause_q;
  logic [6:0]                    cause_d;
  logic [6:0]                    src;
  logic [3:0]                    hold_cnt_q;
  logic [3:0]                    hold_cnt_d;
  logic                          mcd_en_q;
  logic                          mcd_en_d;
  logic                          comp_en_q;
  logic                          comp_en_d;
  logic                          cnv_en_q;
  logic                          cnv_en_d;
  logic                          mon_sel_q;
  logic                          mon_sel_d;
  logic                          pin_oe_q;
  logic                          pin_oe_d;
  logic                          wdt_en_q;
  logic                          wdt_en_d;
  logic [rsw_pkg::WDT_CNT_W-1:0] wdt_cnt_q;
  logic [rsw_pkg::WDT_CNT_W-1:0] wdt_cnt_d;
  logic [rsw_pkg::WDT_CNT_W-1:0] wdt_last;
  logic [2:0]                    interval_q;
  logic [2:0]                    interval_d;
  logic                          lock_q;
  logic                          lock_d;
  logic [2:0]                    arm_q;
  logic [2:0]                    arm_d;
  logic                          wdt_tmo;
  logic                          wr_cause;
  logic                          wr_wdt;
  logic                          ext_hold;
  logic [7:0]                    rdata_d;
  logic [7:0]                    rdata_q;
  logic                          cnv_prev_q;
  logic                          trig_d;
  logic                          trig_q;
  logic                          sysrst_q;

  // every asynchronous level passes two flops before any logic sees it
  assign async_in[rsw_pkg::SY_PIN]  = rst_pin_i;
  assign async_in[rsw_pkg::SY_LOW]  = supply_low_i;
  assign async_in[rsw_pkg::SY_MON]  = supply_monitor_enable_pin_i;
  assign async_in[rsw_pkg::SY_COMP] = comparator_out_i;
  assign async_in[rsw_pkg::SY_CNV]  = second_convert_start_input_i;
  assign async_in[rsw_pkg::SY_MCD]  = mcd_expired;

  genvar gi;
  generate
    for (gi = 0; gi < rsw_pkg::SY_W; gi = gi + 1) begin : g_sync
      always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
          sync1_q[gi] <= rsw_pkg::SY_IDLE[gi]; // start at the idle level
          sync2_q[gi] <= rsw_pkg::SY_IDLE[gi];
        end else begin
          sync1_q[gi] <= async_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // heartbeat level lasts four clocks, else the reference aliases it away
  rsw_missing_clock u_mcd (
    .clk_ref_i    (clk_ref_i),
    .resetn_i     (resetn_i),
    .enable_i     (mcd_en_q),
    .sys_toggle_i (beat_q[2]),
    .expired_o    (mcd_expired)
  );

  // timeout is 2^(6+2n) clocks, so the last count is that minus one
  assign wdt_last = (21'h00_0001 << (rsw_pkg::WDT_EXP_BASE +
                    {1'b0, interval_q, 1'b0})) - 21'h00_0001;
  assign wdt_tmo  = wdt_en_q && (wdt_cnt_q == wdt_last);
  assign wr_cause = sfr_req_i.wr &&
                    (sfr_req_i.addr == rsw_pkg::RESET_CAUSE_AND_ENABLE_ADDR);
  assign wr_wdt   = sfr_req_i.wr &&
                    (sfr_req_i.addr == rsw_pkg::WATCHDOG_CONTROL_ADDR);

  // reset sources; our own pin drive must not read back as a pin reset
  assign src[rsw_pkg::CAUSE_PIN_BIT]  = !sync2_q[rsw_pkg::SY_PIN] && !pin_oe_q;
  assign src[rsw_pkg::CAUSE_POR_BIT]  = (mon_sel_q &&
                                         sync2_q[rsw_pkg::SY_MON] &&
                                         sync2_q[rsw_pkg::SY_LOW]) ||
                                        (wr_cause && sfr_req_i.wdata[0]);
  assign src[rsw_pkg::CAUSE_MCD_BIT]  = sync2_q[rsw_pkg::SY_MCD];
  assign src[rsw_pkg::CAUSE_WDT_BIT]  = wdt_tmo;
  assign src[rsw_pkg::CAUSE_SW_BIT]   = wr_cause && sfr_req_i.wdata[4];
  assign src[rsw_pkg::CAUSE_COMP_BIT] = comp_en_q &&
                                        !sync2_q[rsw_pkg::SY_COMP];
  assign src[rsw_pkg::CAUSE_CNV_BIT]  = cnv_en_q &&
                                        !sync2_q[rsw_pkg::SY_CNV];

  // levels that keep the stretch counter at zero while they last
  assign ext_hold = src[rsw_pkg::CAUSE_PIN_BIT] || sync2_q[rsw_pkg::SY_MCD] ||
                    (mon_sel_q && sync2_q[rsw_pkg::SY_MON] &&
                     sync2_q[rsw_pkg::SY_LOW]);

  // sequencer, cause capture, source enables and watchdog next state
  always_comb begin
    state_d    = state_q;
    cause_d    = cause_q;
    hold_cnt_d = hold_cnt_q;
    mcd_en_d   = mcd_en_q;
    comp_en_d  = comp_en_q;
    cnv_en_d   = cnv_en_q;
    mon_sel_d  = mon_sel_q;
    pin_oe_d   = pin_oe_q;
    wdt_en_d   = wdt_en_q;
    wdt_cnt_d  = wdt_cnt_q;
    interval_d = interval_q;
    lock_d     = lock_q;
    arm_d      = (arm_q != 3'h0) ? arm_q - 3'h1 : 3'h0;
    case (state_q)
      rsw_pkg::ST_RUN: begin
        if (wdt_en_q) begin
          wdt_cnt_d = wdt_cnt_q + 21'h00_0001;
        end
        if (wr_cause) begin
          mcd_en_d  = sfr_req_i.wdata[2];
          comp_en_d = sfr_req_i.wdata[5];
          cnv_en_d  = sfr_req_i.wdata[6];
          if (sync2_q[rsw_pkg::SY_MON]) begin
            mon_sel_d = sfr_req_i.wdata[1];
          end
        end
        if (wr_wdt) begin
          arm_d = 3'h0; // any other write spoils a pending disable
          if (sfr_req_i.wdata == rsw_pkg::WDT_KEY_RELOAD) begin
            wdt_en_d  = 1'b1;
            wdt_cnt_d = '0;
          end else if (sfr_req_i.wdata == rsw_pkg::WDT_KEY_DISABLE_A) begin
            arm_d = rsw_pkg::WDT_DISABLE_WINDOW;
          end else if (sfr_req_i.wdata == rsw_pkg::WDT_KEY_DISABLE_B) begin
            if (arm_q != 3'h0 && !lock_q) begin
              wdt_en_d = 1'b0;
            end
          end else if (sfr_req_i.wdata == rsw_pkg::WDT_KEY_LOCK) begin
            lock_d = 1'b1; // no enable and no reload here
          end
          if (!sfr_req_i.wdata[rsw_pkg::WDT_GUARD_BIT]) begin
            interval_d = sfr_req_i.wdata[2:0];
          end
        end
        if (src != 7'h00) begin
          state_d    = rsw_pkg::ST_HOLD;
          hold_cnt_d = 4'h0;
          // one cause only; lower sources read zero
          if (src[rsw_pkg::CAUSE_POR_BIT]) begin
            cause_d  = 7'h02;
            pin_oe_d = 1'b1; // only power-on style resets drive the pin
          end else if (src[rsw_pkg::CAUSE_PIN_BIT]) begin
            cause_d = 7'h01;
          end else if (src[rsw_pkg::CAUSE_MCD_BIT]) begin
            cause_d = 7'h04;
          end else if (src[rsw_pkg::CAUSE_WDT_BIT]) begin
            cause_d = 7'h08;
          end else if (src[rsw_pkg::CAUSE_SW_BIT]) begin
            cause_d = 7'h10;
          end else if (src[rsw_pkg::CAUSE_COMP_BIT]) begin
            cause_d = 7'h20;
          end else begin
            cause_d = 7'h40;
          end
        end
      end
      rsw_pkg::ST_HOLD: begin
        // whole-system reset: controls except monitor select back to defaults, causes kept
        mcd_en_d   = 1'b0;
        comp_en_d  = 1'b0;
        cnv_en_d   = 1'b0;
        wdt_en_d   = 1'b1;
        wdt_cnt_d  = '0;
        interval_d = rsw_pkg::WDT_INTERVAL_RESET;
        lock_d     = 1'b0;
        arm_d      = 3'h0;
        if (ext_hold) begin
          hold_cnt_d = 4'h0;
        end else if (hold_cnt_q != rsw_pkg::RST_HOLD_LAST) begin
          hold_cnt_d = hold_cnt_q + 4'h1;
        end else begin
          state_d  = rsw_pkg::ST_RUN;
          pin_oe_d = 1'b0;
        end
      end
      default: begin
        state_d = rsw_pkg::ST_RUN;
      end
    endcase
  end

  // read mux and conversion trigger
  always_comb begin
    rdata_d = 8'h00;
    if (sfr_req_i.addr == rsw_pkg::RESET_CAUSE_AND_ENABLE_ADDR) begin
      rdata_d = {1'b0, cause_q};
    end else if (sfr_req_i.addr == rsw_pkg::WATCHDOG_CONTROL_ADDR) begin
      rdata_d = {3'h0, wdt_en_q, 1'b0, interval_q};
    end
    // a reset-configured convert-start input never starts a conversion
    trig_d = cnv_prev_q && !sync2_q[rsw_pkg::SY_CNV] && !cnv_en_q;
  end

  // state registers; causes kept through the hold, rewritten at each reset entry, power-on loads the power-on cause
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q    <= rsw_pkg::ST_RUN;
      cause_q    <= rsw_pkg::CAUSE_RESET;
      hold_cnt_q <= 4'h0;
      mcd_en_q   <= 1'b0;
      comp_en_q  <= 1'b0;
      cnv_en_q   <= 1'b0;
      mon_sel_q  <= 1'b1;
      pin_oe_q   <= 1'b0;
      wdt_en_q   <= 1'b1;
      wdt_cnt_q  <= '0;
      interval_q <= rsw_pkg::WDT_INTERVAL_RESET;
      lock_q     <= 1'b0;
      arm_q      <= 3'h0;
      rdata_q    <= 8'h00;
      cnv_prev_q <= 1'b1;
      trig_q     <= 1'b0;
      sysrst_q   <= 1'b0;
      beat_q     <= 3'h0;
    end else begin
      state_q    <= state_d;
      cause_q    <= cause_d;
      hold_cnt_q <= hold_cnt_d;
      mcd_en_q   <= mcd_en_d;
      comp_en_q  <= comp_en_d;
      cnv_en_q   <= cnv_en_d;
      mon_sel_q  <= mon_sel_d;
      pin_oe_q   <= pin_oe_d;
      wdt_en_q   <= wdt_en_d;
      wdt_cnt_q  <= wdt_cnt_d;
      interval_q <= interval_d;
      lock_q     <= lock_d;
      arm_q      <= arm_d;
      rdata_q    <= rdata_d;
      cnv_prev_q <= sync2_q[rsw_pkg::SY_CNV];
      trig_q     <= trig_d;
      sysrst_q   <= (state_d == rsw_pkg::ST_HOLD);
      beat_q     <= beat_q + 3'h1; // heartbeat for the clock monitor
    end
  end

  assign sfr_rdata_o       = rdata_q;
  assign rst_pin_o         = 1'b0 & pin_oe_q; // open drain: only pulls low
  assign rst_pin_oe_o      = pin_oe_q;
  assign convert_trigger_o = trig_q;
  assign system_reset_o    = sysrst_q;
  assign mcd_reset_o       = mcd_expired;

  // checks on the system clock domain
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence s_wdt_write(logic [7:0] v);
    wr_wdt && sfr_req_i.wdata == v && state_q == rsw_pkg::ST_RUN;
  endsequence

  sequence s_disable_in_time;
    s_wdt_write(rsw_pkg::WDT_KEY_DISABLE_A) ##1 !wr_wdt[*3]
      ##1 (s_wdt_write(rsw_pkg::WDT_KEY_DISABLE_B) && !lock_q && src == 7'h00);
  endsequence

  sequence s_disable_late;
    s_wdt_write(rsw_pkg::WDT_KEY_DISABLE_A) ##1 !wr_wdt[*4]
      ##1 (s_wdt_write(rsw_pkg::WDT_KEY_DISABLE_B) && src == 7'h00);
  endsequence

  chk_wdt_overflow: assert property (
    (wdt_tmo && state_q == rsw_pkg::ST_RUN) |=> system_reset_o)
    else $error("watchdog overflow did not start a reset");
  chk_wdt_defaults: assert property (
    $fell(system_reset_o) |-> (wdt_en_q && interval_q == 3'h7 && !lock_q))
    else $error("watchdog not at defaults after reset");
  chk_reload_key: assert property (
    (s_wdt_write(8'ha5) && src == 7'h00) |=> (wdt_en_q && wdt_cnt_q == '0))
    else $error("reload key did not enable and clear the watchdog");
  chk_disable_ok: assert property (
    s_disable_in_time |=> !wdt_en_q)
    else $error("timely disable pair did not stop the watchdog");
  chk_disable_late: assert property (
    (s_disable_late ##0 wdt_en_q) |=> wdt_en_q)
    else $error("late disable pair was not ignored");
  chk_lock_holds: assert property (
    (lock_q && wdt_en_q && state_q == rsw_pkg::ST_RUN) |=> wdt_en_q)
    else $error("locked watchdog became disabled");
  chk_interval_guard: assert property (
    (wr_wdt && sfr_req_i.wdata[7] && state_q == rsw_pkg::ST_RUN
     && src == 7'h00) |=> $stable(interval_q))
    else $error("interval changed by write with bit 7 set");
  chk_sw_reset: assert property (
    (wr_cause && sfr_req_i.wdata[4] && state_q == rsw_pkg::ST_RUN)
      |=> (system_reset_o && !rst_pin_oe_o))
    else $error("software reset missing or drove the pin");
  chk_pin_only_por: assert property (
    rst_pin_oe_o |-> cause_q == 7'h02)
    else $error("reset pin driven for a non power-on reset");
  chk_force_por: assert property (
    (wr_cause && sfr_req_i.wdata[0] && state_q == rsw_pkg::ST_RUN)
      |=> (rst_pin_oe_o && cause_q == 7'h02))
    else $error("forced power-on reset did not drive the pin");
  chk_comp_reset: assert property (
    (src[5] && src[4:0] == 5'h00 && state_q == rsw_pkg::ST_RUN)
      |=> (system_reset_o && cause_q == 7'h20))
    else $error("comparator low did not reset with its cause");
  chk_hold_stretch: assert property (
    (state_q == rsw_pkg::ST_HOLD && state_d == rsw_pkg::ST_RUN)
      |-> (hold_cnt_q == 4'hb && !ext_hold))
    else $error("reset released before the stretch completed");
  chk_trigger_block: assert property (
    convert_trigger_o |-> $past(!cnv_en_q))
    else $error("conversion started while input is a reset source");

endmodule
`default_nettype wire

// file: verilog/rsw_pkg.sv
// Purpose: shared constants and types for the reset source and watchdog block
// Assumes: 20 MHz system clock, free-running reference for the clock monitor
// Notes:   one byte-wide special function register port, no bus adapter
package rsw_pkg;

  // register addresses on the special function register port
  localparam logic [7:0] RESET_CAUSE_AND_ENABLE_ADDR = 8'hef;
  localparam logic [7:0] WATCHDOG_CONTROL_ADDR       = 8'hff;

  // field positions in reset_cause_and_enable
  localparam int unsigned CAUSE_PIN_BIT  = 0;
  localparam int unsigned CAUSE_POR_BIT  = 1;
  localparam int unsigned CAUSE_MCD_BIT  = 2;
  localparam int unsigned CAUSE_WDT_BIT  = 3;
  localparam int unsigned CAUSE_SW_BIT   = 4;
  localparam int unsigned CAUSE_COMP_BIT = 5;
  localparam int unsigned CAUSE_CNV_BIT  = 6;
  localparam int unsigned CAUSE_W        = 7;

  // after power-on only the power-on cause reads as set
  localparam logic [6:0] CAUSE_RESET = 7'h02;

  // watchdog_control keys and fields
  localparam logic [7:0] WDT_KEY_RELOAD    = 8'ha5;
  localparam logic [7:0] WDT_KEY_DISABLE_A = 8'hde;
  localparam logic [7:0] WDT_KEY_DISABLE_B = 8'had;
  localparam logic [7:0] WDT_KEY_LOCK      = 8'hff;
  localparam int unsigned WDT_GUARD_BIT    = 7;
  localparam int unsigned WDT_STATUS_BIT   = 4;
  localparam logic [2:0] WDT_INTERVAL_RESET = 3'h7;
  localparam logic [4:0] WDT_EXP_BASE       = 5'h06; // log2 of four cubed
  localparam int unsigned WDT_CNT_W         = 21;
  localparam logic [2:0] WDT_DISABLE_WINDOW = 3'h4;

  // internal reset stretch after the last holding level goes away
  localparam logic [3:0] RST_HOLD_CYCLES = 4'hc;
  localparam logic [3:0] RST_HOLD_LAST   = RST_HOLD_CYCLES - 4'h1;

  // missing clock timeout, counted on the reference clock
  localparam int unsigned MCD_TIMEOUT_US = 100;
  localparam int unsigned MCD_REF_KHZ    = 10000;
  localparam int unsigned MCD_TIMEOUT_CYCLES =
    (MCD_TIMEOUT_US * MCD_REF_KHZ + 999) / 1000;
  localparam int unsigned MCD_CNT_W = 11;
  localparam logic [10:0] MCD_LAST  = 11'(MCD_TIMEOUT_CYCLES - 1);

  // synchroniser lanes for asynchronous inputs
  localparam int unsigned SY_PIN  = 0;
  localparam int unsigned SY_LOW  = 1;
  localparam int unsigned SY_MON  = 2;
  localparam int unsigned SY_COMP = 3;
  localparam int unsigned SY_CNV  = 4;
  localparam int unsigned SY_MCD  = 5;
  localparam int unsigned SY_W    = 6;
  // idle level of each lane; a wrong start level would fake a reset source
  localparam logic [5:0]  SY_IDLE = 6'h1d;

  typedef enum logic {ST_RUN, ST_HOLD} rsw_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } rsw_sfr_req_s;

endpackage

// file: verilog/rsw_missing_clock.sv
// Purpose: one-shot that fires when the system clock stops toggling
// Assumes: clk_ref_i runs free and never stops
// Notes:   expired_o stays high until a system clock edge is seen again
`timescale 1ns/1ps
`default_nettype none
module rsw_missing_clock (
  input  wire logic clk_ref_i,
  input  wire logic resetn_i,
  input  wire logic enable_i,
  input  wire logic sys_toggle_i,
  output var  logic expired_o
);

  logic [1:0]                    sync1_q;
  logic [1:0]                    sync2_q;
  logic                          tog_prev_q;
  logic [rsw_pkg::MCD_CNT_W-1:0] cnt_q;
  logic [rsw_pkg::MCD_CNT_W-1:0] cnt_d;
  logic                          expired_q;
  logic                          expired_d;
  logic                          edge_seen;

  // retrigger on every toggle of the system clock divider
  always_comb begin
    edge_seen = sync2_q[1] ^ tog_prev_q;
    cnt_d     = cnt_q;
    expired_d = 1'b0;
    if (!sync2_q[0] || edge_seen) begin
      cnt_d = '0;
    end else if (cnt_q != rsw_pkg::MCD_LAST) begin
      cnt_d = cnt_q + 11'h001;
    end else begin
      expired_d = 1'b1; // limit held: stays set until a clock edge returns
    end
  end

  // reference domain registers; sync2_q is the only reader of sync1_q
  always_ff @(posedge clk_ref_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q    <= 2'h0;
      sync2_q    <= 2'h0;
      tog_prev_q <= 1'b0;
      cnt_q      <= '0;
      expired_q  <= 1'b0;
    end else begin
      sync1_q    <= {sys_toggle_i, enable_i};
      sync2_q    <= sync1_q;
      tog_prev_q <= sync2_q[1];
      cnt_q      <= cnt_d;
      expired_q  <= expired_d;
    end
  end

  assign expired_o = expired_q;

endmodule
`default_nettype wire

// file: testbench/rsw_reset_source_watchdog_test.sv
// Purpose: self-checking bench for reset sources and watchdog
// Assumes: 20 MHz system clock, free 10 MHz reference clock
// Notes:   system clock is gated off once to starve the clock monitor
`timescale 1ns/1ps
`default_nettype none
module rsw_reset_source_watchdog_test;
  logic                  clk_sys_i = 1'b0;
  logic                  clk_ref_i = 1'b0;
  logic                  clk_run   = 1'b1;
  logic                  resetn_i;
  rsw_pkg::rsw_sfr_req_s sfr_req_i;
  logic [7:0]            sfr_rdata_o;
  logic                  rst_pin_i;
  logic                  rst_pin_oe_o;
  logic                  mon_pin;
  logic                  supply_low_i;
  logic                  comparator_out_i;
  logic                  cnv_i;
  logic                  convert_trigger_o;
  logic                  system_reset_o;
  logic                  mcd_reset_o;
  logic                  oe_seen;
  int                    fails = 0;
  int                    samples_checked = 0;
  int                    n;
  int                    pulses = 0;

  // stopping clk_sys_i is the only way to age the clock monitor
  always #25 clk_sys_i = clk_run ? ~clk_sys_i : clk_sys_i;
  always #50 clk_ref_i = ~clk_ref_i;
  always @(posedge clk_sys_i) if (convert_trigger_o === 1'b1) pulses++;

  rsw_reset_source_watchdog rsw_reset_source_watchdog_inst (
    .clk_sys_i(clk_sys_i), .clk_ref_i(clk_ref_i), .resetn_i(resetn_i),
    .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o),
    .rst_pin_i(rst_pin_i), .rst_pin_o(), .rst_pin_oe_o(rst_pin_oe_o),
    .supply_monitor_enable_pin_i(mon_pin), .supply_low_i(supply_low_i),
    .comparator_out_i(comparator_out_i),
    .second_convert_start_input_i(cnv_i),
    .convert_trigger_o(convert_trigger_o), .system_reset_o(system_reset_o),
    .mcd_reset_o(mcd_reset_o));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // strobe held for exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    sfr_req_i <= '{addr: a, wr: 1'b1, wdata: d};
    @(posedge clk_sys_i);
    sfr_req_i.wr <= 1'b0;
  endtask

  // read data is registered, so look one edge after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    sfr_req_i <= '{addr: a, wr: 1'b0, wdata: 8'h00};
    @(posedge clk_sys_i);
    #1 check(sfr_rdata_o, exp);
  endtask

  // bounded wait on the internal reset level, n counts edges
  task automatic wait_rst(input logic lvl, input int max);
    n = 0;
    while (system_reset_o !== lvl) begin
      @(posedge clk_sys_i);
      #1 n++;
      if (system_reset_o === 1'b1) oe_seen = oe_seen | rst_pin_oe_o;
      if (n > max) begin
        fails++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, system_reset_o, lvl);
        stop_test();
      end
    end
  endtask

  // one full reset episode, then the cause and pin drive are compared
  task automatic episode(input logic [7:0] cause, input logic oe);
    oe_seen = 1'b0;
    wait_rst(1'b1, 40);
    wait_rst(1'b0, 60);
    check(8'(oe_seen), 8'(oe));
    rd(rsw_pkg::RESET_CAUSE_AND_ENABLE_ADDR, cause);
    $display("test with cause %h done", cause);
  endtask

  initial begin
    resetn_i = 1'b0;
    sfr_req_i = '0;
    rst_pin_i = 1'b1;
    mon_pin = 1'b1;
    supply_low_i = 1'b0;
    comparator_out_i = 1'b1;
    cnv_i = 1'b1;
    repeat (6) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rd(8'hef, 8'h02);
    rd(8'hff, 8'h17);
    rd(8'h80, 8'h00);
    // shortest interval: reset after four cubed cycles from reload
    wr(8'hff, 8'h00);
    rd(8'hff, 8'h10);
    wr(8'hff, 8'ha5);
    wait_rst(1'b1, 200);
    check(8'(n >= 62 && n <= 66), 8'h01);
    episode(8'h08, 1'b0);
    rd(8'hff, 8'h17);
    // disable pair, late pair, then lockout
    wr(8'hff, 8'hde);
    repeat (2) @(posedge clk_sys_i);
    wr(8'hff, 8'had);
    rd(8'hff, 8'h07);
    wr(8'hff, 8'ha5);
    rd(8'hff, 8'h17);
    wr(8'hff, 8'hde);
    repeat (3) @(posedge clk_sys_i);
    wr(8'hff, 8'had);
    rd(8'hff, 8'h17);
    wr(8'hff, 8'hff);
    wr(8'hff, 8'hde);
    wr(8'hff, 8'had);
    rd(8'hff, 8'h17);
    wr(8'hef, 8'h10);
    episode(8'h10, 1'b0);
    wr(8'hef, 8'h01);
    episode(8'h02, 1'b1);
    // external pin: exit no sooner than twelve cycles after release
    rst_pin_i <= 1'b0;
    wait_rst(1'b1, 20);
    repeat (5) @(posedge clk_sys_i);
    rst_pin_i <= 1'b1;
    wait_rst(1'b0, 60);
    check(8'(n >= 12 && n <= 20), 8'h01);
    rd(8'hef, 8'h01);
    // unarmed convert-start only triggers a conversion
    cnv_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    cnv_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    check(8'(pulses), 8'h01);
    wr(8'hef, 8'h40);
    cnv_i <= 1'b0;
    episode(8'h40, 1'b0);
    cnv_i <= 1'b1;
    check(8'(pulses), 8'h01);
    wr(8'hef, 8'h22); // comparator already high; reselect monitor
    comparator_out_i <= 1'b0;
    episode(8'h20, 1'b0);
    comparator_out_i <= 1'b1;
    supply_low_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    supply_low_i <= 1'b0;
    episode(8'h02, 1'b1);
    // deselected supply monitor must not reset
    wr(8'hef, 8'h00);
    supply_low_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    #1 check(8'(system_reset_o), 8'h00);
    supply_low_i <= 1'b0;
    // starve the clock monitor while the reference keeps running
    wr(8'hef, 8'h04);
    clk_run = 1'b0;
    #120000;
    check(8'(mcd_reset_o), 8'h01);
    clk_run = 1'b1;
    episode(8'h04, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
